/* hdl/gdr_regs.vh */
// Register map, field layout and reset values of the GPIO data and rise-trigger slice
`ifndef GDR_REGS_VH
`define GDR_REGS_VH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define GDR_ADR_W        8
`define GDR_DAT_W        32
`define GDR_SEL_W        4
`define GDR_PIN_W        16

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define GDR_OFS_BANK_EN  8'h08
`define GDR_OFS_DIR      8'h10
`define GDR_OFS_OUT      8'h14
`define GDR_OFS_OUT_SET  8'h18
`define GDR_OFS_OUT_CLR  8'h1C
`define GDR_OFS_IN       8'h20
`define GDR_OFS_RISE_SET 8'h24
`define GDR_OFS_RISE_CLR 8'h28
`define GDR_OFS_EVT_STAT 8'h40
`define GDR_OFS_EVT_MASK 8'h44

// ****************************************************************
// Field positions
// ****************************************************************
`define GDR_BANK_EN_BIT  0

// ****************************************************************
// Reset values
// ****************************************************************
`define GDR_RST_BANK_EN  1'h0
`define GDR_RST_DIR      16'hFFFF
`define GDR_RST_OUT      16'h0000
`define GDR_RST_RISE     16'h0000
`define GDR_RST_STAT     16'h0000
`define GDR_RST_MASK     16'h0000
`define GDR_RST_DATA     32'h0000_0000

// ****************************************************************
// Timing
// ****************************************************************
`define GDR_SYNC_STAGES  2

`endif

/* hdl/gdr_pin_sync.v */
// Two-stage pin synchroniser with per-pin rising-edge detection
module gdr_pin_sync
#(
  parameter WIDTH = 16
)
(
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // Asynchronous pin levels
  input  wire [WIDTH-1:0] async_i,
  // Synchronised level and one-cycle rise pulse
  output wire [WIDTH-1:0] level_o,
  output wire [WIDTH-1:0] rise_o
);

  genvar g;

  // ****************************************************************
  // Per-pin synchroniser and edge detector
  // ****************************************************************
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : pin
      reg meta_q;
      reg sync_q;
      reg prev_q;

      // First stage feeds only the second stage
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          prev_q <= 1'b0;
        end
        else
        begin
          meta_q <= async_i[g];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end

      assign level_o[g] = sync_q;
      assign rise_o[g]  = sync_q & ~prev_q;
    end
  endgenerate

endmodule

/* hdl/gdr_gpio_port.v */
// GPIO data, direction and rising-edge trigger slice behind a Wishbone slave
//
// Notes on behaviour
// - Output value bits 15-0 set the level driven on output pins.
// - Output value does not touch a pin configured as input; pin undriven.
// - Reading output value returns the register, not the pin level.
// - Bits 31-16 of every register read zero; writes there ignored.
// - Writing 1 to set-output alias sets that output bit; 0 no change.
// - Writing 1 to clear-output alias clears that output bit; 0 no change.
// - Reading either output alias returns the output value register.
// - Input register returns actual pin levels, whatever direction or output value.
// - Input register is read-only; bits 15-0 give pin levels.
// - Rise mask bit 1 raises pin event on each low-to-high pin change.
// - Rise mask has no address; changed only through set and clear aliases.
// - Writing 1 to set-rising alias sets that mask bit; 0 leaves it.
// - Reading set-rising alias returns the rise mask.
// - Direction 0 makes pin output from output value; 1 makes it input.
// - Pin events reach the processor only while bank enable bit 0 is 1.
// - Writing 1 to clear-rising alias clears that mask bit.
`include "gdr_regs.vh"

module gdr_gpio_port
#(
  parameter PINS = `GDR_PIN_W
)
(
  // Clock and reset
  input  wire                  clk_i,
  input  wire                  rst_i,
  // Wishbone classic slave
  input  wire                  wb_cyc_i,
  input  wire                  wb_stb_i,
  input  wire                  wb_we_i,
  input  wire [`GDR_ADR_W-1:0] wb_adr_i,
  input  wire [`GDR_SEL_W-1:0] wb_sel_i,
  input  wire [`GDR_DAT_W-1:0] wb_dat_i,
  output reg  [`GDR_DAT_W-1:0] wb_dat_o,
  output reg                   wb_ack_o,
  // Port pins, split into input, output and active-low enable
  input  wire [PINS-1:0]       port_pin_i,
  output reg  [PINS-1:0]       port_pin_o,
  output reg  [PINS-1:0]       port_pin_oe_n_o,
  // Pin events
  output reg  [PINS-1:0]       pin_event_out_o,
  output reg                   irq_o
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Address match on a word-aligned offset
  function hit;
    input [`GDR_ADR_W-1:0] adr;
    input [`GDR_ADR_W-1:0] ofs;
    begin
      hit = (adr[`GDR_ADR_W-1:2] == ofs[`GDR_ADR_W-1:2]);
    end
  endfunction

  // Byte enables widened to a bit mask over the low half-word
  function [15:0] lane_mask;
    input [`GDR_SEL_W-1:0] sel;
    begin
      lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  // Zero-extend a pin-wide value to bus width
  function [`GDR_DAT_W-1:0] widen;
    input [PINS-1:0] val;
    begin
      widen = {`GDR_DAT_W{1'b0}};
      widen[PINS-1:0] = val;
    end
  endfunction

  // ****************************************************************
  // Bus handshake state
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ACK  = 2'b10;

  reg  [1:0]            state_q;
  reg  [1:0]            state_d;

  // ****************************************************************
  // Registers and next values
  // ****************************************************************
  reg                   bank_en_q;
  reg                   bank_en_d;
  reg  [PINS-1:0]       dir_q;
  reg  [PINS-1:0]       dir_d;
  reg  [PINS-1:0]       out_q;
  reg  [PINS-1:0]       out_d;
  reg  [PINS-1:0]       rise_q;
  reg  [PINS-1:0]       rise_d;
  reg  [PINS-1:0]       stat_q;
  reg  [PINS-1:0]       stat_d;
  reg  [PINS-1:0]       imask_q;
  reg  [PINS-1:0]       imask_d;
  reg  [`GDR_DAT_W-1:0] rdata_d;
  reg                   mapped_d;

  wire [15:0]           lanes_w;
  wire [PINS-1:0]       wmask_w;
  wire [PINS-1:0]       wbits_w;
  wire                  req_w;
  wire                  wr_w;
  wire [PINS-1:0]       level_w;
  wire [PINS-1:0]       rise_w;
  wire [PINS-1:0]       evt_w;
  wire                  take_w;
  wire                  irq_w;

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  gdr_pin_sync
  #(
    .WIDTH   (PINS)
  )
  u_sync
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (port_pin_i),
    .level_o (level_w),
    .rise_o  (rise_w)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign req_w   = wb_cyc_i & wb_stb_i;
  // Taken only from idle, so a strobe held past ack is not answered twice
  assign take_w  = (state_q == ST_IDLE) & req_w;
  // Writes take effect on the edge that the master sees ack
  assign wr_w    = req_w & wb_we_i & wb_ack_o;
  assign lanes_w = lane_mask(wb_sel_i);
  assign wmask_w = lanes_w[PINS-1:0];
  // Upper data bits never reach a register
  assign wbits_w = wb_dat_i[PINS-1:0] & wmask_w;

  always @*
  begin
    state_d = ST_IDLE;
    case (state_q)
      ST_IDLE:
      begin
        if (req_w)
        begin
          state_d = ST_ACK;
        end
      end
      ST_ACK:
      begin
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  // Unmapped offsets answer with zero data and take no write
  always @*
  begin
    rdata_d  = `GDR_RST_DATA;
    mapped_d = 1'b1;
    if (hit(wb_adr_i, `GDR_OFS_BANK_EN))
    begin
      rdata_d[`GDR_BANK_EN_BIT] = bank_en_q;
    end
    else if (hit(wb_adr_i, `GDR_OFS_DIR))
    begin
      rdata_d = widen(dir_q);
    end
    else if (hit(wb_adr_i, `GDR_OFS_OUT) |
             hit(wb_adr_i, `GDR_OFS_OUT_SET) |
             hit(wb_adr_i, `GDR_OFS_OUT_CLR))
    begin
      rdata_d = widen(out_q);
    end
    else if (hit(wb_adr_i, `GDR_OFS_IN))
    begin
      rdata_d = widen(level_w);
    end
    else if (hit(wb_adr_i, `GDR_OFS_RISE_SET) |
             hit(wb_adr_i, `GDR_OFS_RISE_CLR))
    begin
      rdata_d = widen(rise_q);
    end
    else if (hit(wb_adr_i, `GDR_OFS_EVT_STAT))
    begin
      rdata_d = widen(stat_q);
    end
    else if (hit(wb_adr_i, `GDR_OFS_EVT_MASK))
    begin
      rdata_d = widen(imask_q);
    end
    else
    begin
      mapped_d = 1'b0;
    end
  end

  // ****************************************************************
  // Register write logic
  // ****************************************************************
  // Byte enables 0 and 1 each guard their own eight pins of a written register; enables 2 and 3 guard nothing
  always @*
  begin
    bank_en_d = bank_en_q;
    dir_d     = dir_q;
    out_d     = out_q;
    rise_d    = rise_q;
    imask_d   = imask_q;
    if (wr_w)
    begin
      if (hit(wb_adr_i, `GDR_OFS_BANK_EN) & wb_sel_i[0])
      begin
        bank_en_d = wb_dat_i[`GDR_BANK_EN_BIT];
      end
      if (hit(wb_adr_i, `GDR_OFS_DIR))
      begin
        dir_d = (dir_q & ~wmask_w) | wbits_w;
      end
      if (hit(wb_adr_i, `GDR_OFS_OUT))
      begin
        out_d = (out_q & ~wmask_w) | wbits_w;
      end
      if (hit(wb_adr_i, `GDR_OFS_OUT_SET))
      begin
        out_d = out_q | wbits_w;
      end
      if (hit(wb_adr_i, `GDR_OFS_OUT_CLR))
      begin
        out_d = out_q & ~wbits_w;
      end
      // The trigger mask itself has no address of its own
      if (hit(wb_adr_i, `GDR_OFS_RISE_SET))
      begin
        rise_d = rise_q | wbits_w;
      end
      if (hit(wb_adr_i, `GDR_OFS_RISE_CLR))
      begin
        rise_d = rise_q & ~wbits_w;
      end
      if (hit(wb_adr_i, `GDR_OFS_EVT_MASK))
      begin
        imask_d = (imask_q & ~wmask_w) | wbits_w;
      end
    end
  end

  // ****************************************************************
  // Event detection and sticky status
  // ****************************************************************
  // Armed rising edges, passed on only while the bank is enabled
  assign evt_w = rise_w & rise_q & {PINS{bank_en_q}};

  always @*
  begin
    stat_d = stat_q;
    if (wr_w & hit(wb_adr_i, `GDR_OFS_EVT_STAT))
    begin
      stat_d = stat_q & ~wbits_w;
    end
    // A new event beats a clear in the same cycle
    stat_d = stat_d | evt_w;
  end

  // Level interrupt follows the next status and mask, so it moves with them
  assign irq_w = |(stat_d & imask_d);

  // ****************************************************************
  // State registers
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q   <= ST_IDLE;
      bank_en_q <= `GDR_RST_BANK_EN;
      dir_q     <= `GDR_RST_DIR;
      out_q     <= `GDR_RST_OUT;
      rise_q    <= `GDR_RST_RISE;
      stat_q    <= `GDR_RST_STAT;
      imask_q   <= `GDR_RST_MASK;
    end
    else
    begin
      state_q   <= state_d;
      bank_en_q <= bank_en_d;
      dir_q     <= dir_d;
      out_q     <= out_d;
      rise_q    <= rise_d;
      stat_q    <= stat_d;
      imask_q   <= imask_d;
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o        <= 1'b0;
      wb_dat_o        <= `GDR_RST_DATA;
      port_pin_o      <= `GDR_RST_OUT;
      port_pin_oe_n_o <= `GDR_RST_DIR;
      pin_event_out_o <= {PINS{1'b0}};
      irq_o           <= 1'b0;
    end
    else
    begin
      wb_ack_o <= take_w;
      if (take_w & mapped_d)
      begin
        wb_dat_o <= rdata_d;
      end
      else
      begin
        wb_dat_o <= `GDR_RST_DATA;
      end
      // Pin value follows the output register; enable follows direction
      port_pin_o      <= out_d;
      port_pin_oe_n_o <= dir_d;
      pin_event_out_o <= evt_w;
      irq_o           <= irq_w;
    end
  end

endmodule

/* tb/gdr_pin_model.sv */
// Board-side model of the sixteen port pins
module gdr_pin_model
(
  // Port side
  input  wire logic [15:0] drv_i,
  input  wire logic [15:0] oe_n_i,
  // Board side
  input  wire logic [15:0] ext_i,
  output wire logic [15:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven pins follow the port, released pins follow the board
  assign pin_o = (drv_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule

/* tb/gdr_gpio_port_asserts.sv */
// Port-level checks of the GPIO data and rise-trigger slice
module gdr_gpio_port_asserts
#(
  parameter PINS = 16
)
(
  // Clock and reset
  input wire logic            clk_i,
  input wire logic            rst_i,
  // Wishbone
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_we_i,
  input wire logic [7:0]      wb_adr_i,
  input wire logic [3:0]      wb_sel_i,
  input wire logic [31:0]     wb_dat_i,
  input wire logic [31:0]     wb_dat_o,
  input wire logic            wb_ack_o,
  // Pins and events
  input wire logic [PINS-1:0] port_pin_i,
  input wire logic [PINS-1:0] port_pin_o,
  input wire logic [PINS-1:0] port_pin_oe_n_o,
  input wire logic [PINS-1:0] pin_event_out_o,
  input wire logic            irq_o
);
  wire       wr_done = wb_ack_o & wb_we_i & (wb_sel_i[1:0] == 2'h3);
  wire [15:0] wd     = wb_dat_i[15:0];
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ****
  // Checks
  // ****
  ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  out_write_a: assert property (wr_done && wb_adr_i == 8'h14 |=> port_pin_o == $past(wd))
    else $error("output write not on pins");
  set_alias_a: assert property (wr_done && wb_adr_i == 8'h18 |=>
    port_pin_o == ($past(port_pin_o) | $past(wd))) else $error("set alias wrong");
  clr_alias_a: assert property (wr_done && wb_adr_i == 8'h1C |=>
    port_pin_o == ($past(port_pin_o) & ~$past(wd))) else $error("clear alias wrong");
  dir_write_a: assert property (wr_done && wb_adr_i == 8'h10 |=> port_pin_oe_n_o == $past(wd))
    else $error("direction not on enables");
  read_out_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i inside {8'h14, 8'h18, 8'h1C}
    |-> wb_dat_o == {16'h0000, port_pin_o}) else $error("output read wrong");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  evt_pulse_a: assert property (pin_event_out_o != 0 |=> (pin_event_out_o & $past(pin_event_out_o)) == 0)
    else $error("event longer than one cycle");
  evt_cause_a: assert property (pin_event_out_o != 0 |->
    (pin_event_out_o & ~($past(port_pin_i, 3) & ~$past(port_pin_i, 4))) == 0)
    else $error("event without a pin rise");
  irq_cause_a: assert property ($rose(irq_o) |-> pin_event_out_o != 0 || $past(wr_done))
    else $error("interrupt without cause");
  evt_seen_c: cover property (pin_event_out_o != 0);
  irq_seen_c: cover property ($rose(irq_o));
  wr_seen_c: cover property (wr_done);
endmodule

/* tb/gdr_gpio_port_tb.sv */
// Self-checking bench of the GPIO data and rise-trigger slice
module gdr_gpio_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, cyc, stb, we, ack, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [15:0] ext, pins, drv, oe_n, evt;
  int          bad_count, n_compared;

  gdr_gpio_port u_gdr_gpio_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .port_pin_i(pins), .port_pin_o(drv), .port_pin_oe_n_o(oe_n),
    .pin_event_out_o(evt), .irq_o(irq));
  gdr_pin_model u_gdr_pin_model (.drv_i(drv), .oe_n_i(oe_n), .ext_i(ext), .pin_o(pins));

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ****
  // Helpers
  // ****
  task summarize();
    $display("TB: compared %0d wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s exp %h seen %h", n, e, g);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
          output logic [31:0] r);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk_i);
      if (ack === 1'b1)
        break;
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 16)
    begin
      bad_count++;
      summarize();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, 4'hF, d, r);
  endtask
  // Write with only some byte lanes enabled
  task wr_lane(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    wb(1'b1, a, s, d, r);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 4'hF, 32'h0000_0000, r);
    chk($sformatf("reg_%h", a), e, r);
  endtask
  // Drive board levels, then gather events over six edges
  task ev(input logic [15:0] e, input logic [15:0] lv);
    logic [15:0] s;
    int          n;
    s = 16'h0000;
    n = 0;
    @(posedge clk_i);
    ext <= lv;
    repeat (6)
    begin
      @(posedge clk_i);
      s = s | evt;
      if (evt !== 16'h0000)
        n++;
    end
    chk("event", {16'h0000, e}, {16'h0000, s});
    chk("pulses", {31'h0, e != 16'h0000}, n);
  endtask
  // ****
  // Scenarios
  // ****
  task t_data();
    rd(8'h14, 32'h0000_0000);
    rd(8'h24, 32'h0000_0000);
    chk("oe_n", 32'h0000_FFFF, {16'h0000, oe_n});
    wr(8'h14, 32'hFFFF_A5C3);
    ext <= 16'h0F0F;
    rd(8'h14, 32'h0000_A5C3);
    rd(8'h20, 32'h0000_0F0F);
    wr(8'h10, 32'hFFFF_FF00);
    repeat (3) @(posedge clk_i);
    rd(8'h20, 32'h0000_0FC3);
    rd(8'h10, 32'h0000_FF00);
    wr(8'h20, 32'h0000_FFFF);
    rd(8'h20, 32'h0000_0FC3);
    rd(8'hFC, 32'h0000_0000);
  endtask
  task t_alias();
    wr(8'h18, 32'hFFFF_0F00);
    rd(8'h18, 32'h0000_AFC3);
    wr(8'h1C, 32'h0000_00C1);
    rd(8'h1C, 32'h0000_AF02);
    chk("pin_o", 32'h0000_AF02, {16'h0000, drv});
    wr_lane(8'h14, 32'h0000_1234, 4'h1);
    rd(8'h14, 32'h0000_AF34);
    wr(8'h10, 32'h0000_FFFF);
    ext <= 16'h0000;
  endtask
  task t_event();
    wr(8'h08, 32'h0000_0001);
    wr(8'h44, 32'h0000_0001);
    wr(8'h24, 32'h0000_0003);
    rd(8'h24, 32'h0000_0003);
    rd(8'h28, 32'h0000_0003);
    ev(16'h0003, 16'h0003);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h40, 32'h0000_0001);
    @(posedge clk_i);
    chk("irq", 32'h0, {31'h0, irq});
    ev(16'h0000, 16'h0000);
    wr(8'h28, 32'h0000_0001);
    rd(8'h24, 32'h0000_0002);
    ev(16'h0002, 16'h0003);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h44, 32'h0000_0003);
    @(posedge clk_i);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h40, 32'h0000_0002);
    @(posedge clk_i);
    chk("irq", 32'h0, {31'h0, irq});
    ev(16'h0000, 16'h0000);
    wr(8'h08, 32'h0000_0000);
    ev(16'h0000, 16'h0003);
  endtask

  initial
  begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    ext = 16'h0000;
    bad_count = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_data();
    t_alias();
    t_event();
    summarize();
  end
endmodule

bind gdr_gpio_port gdr_gpio_port_asserts #(.PINS(PINS)) u_gdr_gpio_port_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .port_pin_i(port_pin_i), .port_pin_o(port_pin_o),
  .port_pin_oe_n_o(port_pin_oe_n_o), .pin_event_out_o(pin_event_out_o), .irq_o(irq_o));
